// *** design/ezs_sync2.sv ***
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module ezs_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);
   // Both stages as one state word
   typedef struct packed {
      logic [WIDTH-1:0] s1;   // First stage, read only by the second
      logic [WIDTH-1:0] s2;   // Second stage, safe to use
   } ezs_sync_st_t;

   ezs_sync_st_t st;
   ezs_sync_st_t next_st;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("ezs_sync2 width must be positive");
      end
   endgenerate

   // Shift the level through both stages
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // No reset: contents settle within two edges
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign q = st.s2;
endmodule

// *** design/ezs_zone_timing.sv ***
// External zone access engine: lead, active and trail strobe timing
//
// Functional notes
// - No checking of timing fields; executed as programmed
// - Output clock equals or halves the timing clock
// - Phases counted, strobes change on timing edges
// - Full rate: strobes align to output rising edge
// - Half rate: even count rising, odd falling
// - Accesses start on output clock rising edge
// - Strobe assertion aligns by lead count parity
// - Strobe release aligns by lead+active parity
// - Select release aligns by total access parity
// - Lead/trail field, active field+waits+1; doubler doubles only the fields
// - Ready ignored means zero wait states
// - Alignment cycle inserted, strobes held inactive
// - Address bus holds last address when idle
`timescale 1ns/1ps
module ezs_zone_timing #(
   parameter int ADDR_W = ezs_pkg::ADDR_W
) (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire ezs_pkg::ezs_zone_cfg_t zone_timing_config,
   input  wire logic                  access_start,
   input  wire logic                  access_write,
   input  wire logic [ADDR_W-1:0]     access_addr,
   output      logic                  access_busy,
   output      logic                  access_done,
   input  wire logic                  interface_timing_clock,
   input  wire logic                  external_ready_input,
   output      logic                  interface_output_clock,
   output      logic                  zone_select_n,
   output      logic                  read_strobe_n,
   output      logic                  write_strobe_n,
   output      logic                  read_not_write,
   output      logic [ADDR_W-1:0]     external_address_bus
);
   localparam int CW = ezs_pkg::CNT_W;

   generate
      if (ADDR_W < 1) begin : g_chk
         $error("ezs_zone_timing address width must be positive");
      end
   endgenerate

   // System-side state
   typedef struct packed {
      logic              busy;       // Access in flight
      logic              req_tgl;    // Toggles once per request
      logic              done_seen;  // Last completion toggle observed
      logic              done_p;     // Completion pulse
      logic              wr;         // Held direction of the request
      logic [ADDR_W-1:0] addr;       // Held address, stable while busy
   } ezs_sys_st_t;

   // Timing-clock side state
   typedef struct packed {
      ezs_pkg::ezs_state_t st;       // Engine state
      logic [CW-1:0]       cnt;      // Cycles left in the phase
      logic                oclk;     // Half-rate output clock level
      logic                par;      // Parity of cycles since access start
      logic                zcs_n;    // Zone select
      logic                rd_n;     // Read strobe
      logic                wr_n;     // Write strobe
      logic                rnw;      // Read-not-write
      logic [ADDR_W-1:0]   addr;     // Driven address
      logic                req_seen; // Last request toggle accepted
      logic                done_tgl; // Toggles once per finished access
      logic                is_wr;    // Direction of the running access
      logic                rdy_d;    // Extra ready stage for async sampling
   } ezs_link_st_t;

   ezs_sys_st_t            s;
   ezs_sys_st_t            next_s;
   ezs_link_st_t           t;
   ezs_link_st_t           next_t;
   ezs_pkg::ezs_zone_cfg_t cfg_s;    // Configuration seen by the engine
   logic                   rdy_s;    // Synchronised ready
   logic                   req_s;    // Synchronised request toggle
   logic                   done_s;   // Synchronised completion toggle
   logic                   trst_n;   // Reset in the timing domain
   ezs_pkg::ezs_phase_cfg_t ph;      // Fields of the selected direction
   logic                   wr_sel;   // Direction used for field selection
   logic                   rdy_eff;  // Ready after the selected sampling
   logic [CW-1:0]          lead_c;   // Effective lead cycles
   logic [CW-1:0]          act_c;    // Effective base active cycles
   logic [CW-1:0]          trail_c;  // Effective trail cycles

   // Field value in cycles, doubled when asked
   function automatic logic [CW-1:0] eff_len(input logic [CW-1:0] f, input logic dbl);
      eff_len = dbl ? CW'(f * CW'(ezs_pkg::DBL_FACTOR)) : f;
   endfunction

   // Crossings into the timing domain
   ezs_sync2 #(.WIDTH($bits(ezs_pkg::ezs_zone_cfg_t))) u_cfg (
      .clk (interface_timing_clock),
      .d   (zone_timing_config),
      .q   (cfg_s)
   );
   ezs_sync2 #(.WIDTH(1)) u_rdy (
      .clk (interface_timing_clock),
      .d   (external_ready_input),
      .q   (rdy_s)
   );
   ezs_sync2 #(.WIDTH(1)) u_req (
      .clk (interface_timing_clock),
      .d   (s.req_tgl),
      .q   (req_s)
   );
   ezs_sync2 #(.WIDTH(1)) u_rst (
      .clk (interface_timing_clock),
      .d   (nrst),
      .q   (trst_n)
   );
   // Completion back to the system clock
   ezs_sync2 #(.WIDTH(1)) u_done (
      .clk (mclk),
      .d   (t.done_tgl),
      .q   (done_s)
   );

   // System side: accept a request, hold it until completion returns
   always_comb begin
      next_s = s;
      next_s.done_p = 1'b0;
      if (s.busy && (done_s != s.done_seen)) begin
         next_s.busy = 1'b0;
         next_s.done_seen = done_s;
         next_s.done_p = 1'b1;
      end else if (!s.busy && access_start) begin
         next_s.busy = 1'b1;
         next_s.req_tgl = ~s.req_tgl;
         next_s.wr = access_write;
         next_s.addr = access_addr;
      end
   end

   // System-side registers
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Field values go straight into the counters, never validated
   always_comb begin
      wr_sel = (t.st == ezs_pkg::EZS_IDLE || t.st == ezs_pkg::EZS_ALIGN) ? s.wr : t.is_wr;
      ph = wr_sel ? cfg_s.wr : cfg_s.rd;
      lead_c = eff_len(CW'(ph.lead), cfg_s.period_doubler);
      act_c = CW'(eff_len(CW'(ph.active), cfg_s.period_doubler) + CW'(ezs_pkg::ACT_EXTRA));
      trail_c = eff_len(CW'(ph.trail), cfg_s.period_doubler);
      rdy_eff = cfg_s.ready_async_select ? t.rdy_d : rdy_s;
   end

   // Engine: phases counted in timing-clock cycles
   always_comb begin
      next_t = t;
      next_t.rdy_d = rdy_s;
      next_t.par = ~t.par;
      // Half rate toggles each cycle, full rate keeps the phase high
      next_t.oclk = cfg_s.output_clock_half ? ~t.oclk : 1'b1;
      case (t.st)
         ezs_pkg::EZS_IDLE, ezs_pkg::EZS_ALIGN: begin
            if (req_s != t.req_seen) begin
               if (cfg_s.output_clock_half && t.oclk && t.st == ezs_pkg::EZS_IDLE) begin
                  next_t.st = ezs_pkg::EZS_ALIGN; // Next edge falls: wait one
               end else begin
                  // Start where the output clock rises
                  next_t.req_seen = req_s;
                  next_t.is_wr = s.wr;
                  next_t.addr = s.addr;
                  next_t.par = 1'b0;
                  if (lead_c != '0) begin
                     next_t.st = ezs_pkg::EZS_LEAD;
                     next_t.cnt = CW'(lead_c - CW'(1));
                  end else begin
                     next_t.st = ezs_pkg::EZS_ACTIVE;
                     next_t.cnt = CW'(act_c - CW'(1));
                  end
               end
            end else begin
               next_t.st = ezs_pkg::EZS_IDLE;
            end
         end
         ezs_pkg::EZS_LEAD: begin
            if (t.cnt != '0) begin
               next_t.cnt = CW'(t.cnt - CW'(1));
            end else begin
               next_t.st = ezs_pkg::EZS_ACTIVE;
               next_t.cnt = CW'(act_c - CW'(1));
            end
         end
         ezs_pkg::EZS_ACTIVE: begin
            if (t.cnt != '0) begin
               next_t.cnt = CW'(t.cnt - CW'(1));
            end else if (cfg_s.ready_sampling_enable && !rdy_eff) begin
               next_t.st = ezs_pkg::EZS_ACTIVE; // One wait state per low sample
            end else if (trail_c != '0) begin
               // Ready ignored adds no wait state
               next_t.st = ezs_pkg::EZS_TRAIL;
               next_t.cnt = CW'(trail_c - CW'(1));
            end else begin
               next_t.st = ezs_pkg::EZS_IDLE;
               next_t.done_tgl = ~t.done_tgl;
            end
         end
         ezs_pkg::EZS_TRAIL: begin
            if (t.cnt != '0) begin
               next_t.cnt = CW'(t.cnt - CW'(1));
            end else begin
               next_t.st = ezs_pkg::EZS_IDLE;
               next_t.done_tgl = ~t.done_tgl;
            end
         end
         default: begin
            next_t.st = ezs_pkg::EZS_IDLE;
         end
      endcase
      // Strobes follow the next state, so each changes on a timing edge
      next_t.zcs_n = (next_t.st == ezs_pkg::EZS_IDLE || next_t.st == ezs_pkg::EZS_ALIGN);
      next_t.rd_n = !(next_t.st == ezs_pkg::EZS_ACTIVE && !next_t.is_wr);
      next_t.wr_n = !(next_t.st == ezs_pkg::EZS_ACTIVE && next_t.is_wr);
      next_t.rnw = !(!next_t.zcs_n && next_t.is_wr);
   end

   // Timing-domain registers
   always_ff @(posedge interface_timing_clock) begin
      if (!trst_n) begin
         t <= '0;
         t.st <= ezs_pkg::EZS_IDLE;
         t.oclk <= ezs_pkg::OCLK_RST;
         t.zcs_n <= ezs_pkg::STROBE_OFF;
         t.rd_n <= ezs_pkg::STROBE_OFF;
         t.wr_n <= ezs_pkg::STROBE_OFF;
         t.rnw <= ezs_pkg::RNW_RST;
      end else begin
         t <= next_t;
      end
   end

   // Full rate passes the timing clock so all edges are rising edges
   assign interface_output_clock = cfg_s.output_clock_half ? t.oclk : interface_timing_clock;
   assign zone_select_n = t.zcs_n;
   assign read_strobe_n = t.rd_n;
   assign write_strobe_n = t.wr_n;
   assign read_not_write = t.rnw;
   assign external_address_bus = t.addr; // Held between accesses
   assign access_busy = s.busy;
   assign access_done = s.done_p;

   // Alignment cycles keep every strobe inactive
   a_align_inactive: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      t.st == ezs_pkg::EZS_ALIGN |-> t.zcs_n && t.rd_n && t.wr_n && t.rnw)
      else $error("strobe active during alignment");
   // Access start lands on a rising output edge
   a_start_rising: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      cfg_s.output_clock_half && $fell(t.zcs_n) |-> t.oclk && !t.par)
      else $error("access began off a rising output edge");
   // Read-not-write falls only with select
   a_rnw_with_select: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      $fell(t.rnw) |-> $fell(t.zcs_n))
      else $error("read-not-write fell apart from select");
   // Data strobe edges follow cycle parity
   a_strobe_parity: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      cfg_s.output_clock_half && ($changed(t.rd_n) || $changed(t.wr_n)) |-> t.oclk == !t.par)
      else $error("strobe edge on wrong output phase");
   // Select release follows total cycle parity
   a_end_parity: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      cfg_s.output_clock_half && $rose(t.zcs_n) |-> t.oclk == !t.par)
      else $error("select released on wrong output phase");
   // One-cycle lead gives a strobe on the next edge
   a_lead_one: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      $fell(t.zcs_n) && t.st == ezs_pkg::EZS_LEAD && $past(lead_c) == CW'(1)
      |=> !(t.rd_n && t.wr_n))
      else $error("lead length wrong");
   // Ignored ready never stretches active
   a_no_wait: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      !cfg_s.ready_sampling_enable && t.st == ezs_pkg::EZS_ACTIVE && t.cnt == '0
      |=> t.st != ezs_pkg::EZS_ACTIVE)
      else $error("wait state without ready sampling");
   // A low ready sample stretches active by one
   a_wait_extend: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      cfg_s.ready_sampling_enable && t.st == ezs_pkg::EZS_ACTIVE && t.cnt == '0 && !rdy_eff
      |=> t.st == ezs_pkg::EZS_ACTIVE && t.cnt == '0 && !t.rd_n == !t.is_wr)
      else $error("not-ready sample did not extend active");
   // Address holds while no access runs
   a_addr_hold: assert property (@(posedge interface_timing_clock) disable iff (!trst_n)
      $past(trst_n) && !$stable(t.addr) |-> $fell(t.zcs_n))
      else $error("address changed while idle");
endmodule

// *** inc/ezs_pkg.sv ***
// Shared constants, states and carrier types of the zone strobe timing block
package ezs_pkg;
   localparam int LEAD_W = 2;                 // Lead field width
   localparam int ACT_W  = 3;                 // Active field width
   localparam int TRAIL_W = 2;                // Trail field width
   localparam int ADDR_W = 19;                // External address width
   localparam int CNT_W  = 8;                 // Phase cycle counter width
   localparam int DBL_FACTOR = 2;             // Doubler multiplier
   localparam int ACT_EXTRA = 1;              // Fixed extra active cycle
   localparam logic STROBE_OFF = 1'b1;        // Inactive level of low-true strobes
   localparam logic RNW_RST = 1'b1;           // Read-not-write level after reset
   localparam logic OCLK_RST = 1'b1;          // Output clock phase after reset

   // Access engine states, one-hot
   typedef enum logic [4:0] {
      EZS_IDLE   = 5'h01,
      EZS_ALIGN  = 5'h02,
      EZS_LEAD   = 5'h04,
      EZS_ACTIVE = 5'h08,
      EZS_TRAIL  = 5'h10
   } ezs_state_t;

   // Lead, active and trail fields of one direction
   typedef struct packed {
      logic [LEAD_W-1:0]  lead;
      logic [ACT_W-1:0]   active;
      logic [TRAIL_W-1:0] trail;
   } ezs_phase_cfg_t;

   // Zone timing configuration
   typedef struct packed {
      ezs_phase_cfg_t rd;                      // Read timing fields
      ezs_phase_cfg_t wr;                      // Write timing fields
      logic           period_doubler;          // Multiply fields by two
      logic           ready_sampling_enable;   // Use external ready
      logic           ready_async_select;      // Ready sampled asynchronously
      logic           output_clock_half;       // Output clock at half timing clock
   } ezs_zone_cfg_t;
endpackage

// *** tb/ezs_mem_model.sv ***
// Far-side memory model that answers each access on the external ready line
`timescale 1ns/1ps
module ezs_mem_model (
   input  wire logic       interface_timing_clock,
   input  wire logic       zone_select_n,
   input  wire logic [3:0] hold,
   output      logic       external_ready_input
);
   int cnt;  // Timing cycles since select went low

   // Count select-low cycles; cleared while the zone is not selected
   always @(posedge interface_timing_clock) begin
      if (zone_select_n) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end

   // Not ready for the first hold cycles of an access; pulled up outside accesses
   assign external_ready_input = zone_select_n | (cnt >= int'(hold));
endmodule

// *** tb/ezs_zone_timing_tb.sv ***
// Self-checking bench of the zone strobe timing engine
`timescale 1ns/1ps
module ezs_zone_timing_tb;
   // One access: settings beside the phase lengths they should give
   typedef struct packed {
      logic       wr;
      logic [1:0] ld;
      logic [2:0] ac;
      logic [1:0] tr;
      logic       dbl, half, use_rdy, asy;
      logic [3:0] hold, e_ld, e_ac, e_tr;
   } ezs_row_t;

   localparam int RST_CYC = 60;  // Long enough for four timing edges
   localparam int RST_START = 20;  // Power-up reset length in system cycles
   logic                          mclk, nrst, tclk, start, wr, busy, done, rdy, oclk;
   logic                          sel_n, rd_n, wr_n, rnw, cur_wr, sel_q, stb_q, mon_en;
   logic [ezs_pkg::ADDR_W-1:0]    addr, xaddr, cur_addr;
   ezs_pkg::ezs_zone_cfg_t        cfg;
   logic [3:0]                    hold;
   int                            err_total, n_checks, cyc, n_sel, lead_m, act_m, tot_m;
   ezs_row_t                      rows [12];

   ezs_zone_timing i_dut (.mclk(mclk), .nrst(nrst), .zone_timing_config(cfg),
      .access_start(start), .access_write(wr), .access_addr(addr), .access_busy(busy),
      .access_done(done), .interface_timing_clock(tclk), .external_ready_input(rdy),
      .interface_output_clock(oclk), .zone_select_n(sel_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .read_not_write(rnw), .external_address_bus(xaddr));
   ezs_mem_model i_mem (.interface_timing_clock(tclk), .zone_select_n(sel_n),
      .hold(hold), .external_ready_input(rdy));

   // System clock and an unrelated 125 ns timing clock
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      tclk = 1'h0;
      #37;
      forever #62.5 tclk = ~tclk;
   end

   // Compare design values and counted lengths
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic chk_num(input int got, input int exp);
      chk_val(got, exp);
   endtask

   // Expected output clock level right after a strobe edge
   function automatic logic edge_lvl();
      return cfg.output_clock_half ? logic'(cyc % 2 == 0) : 1'h1;
   endfunction

   // Watch the memory side each timing edge once outputs have settled
   always @(posedge tclk) begin
      #1;
      cyc = cyc + 1;
      if (mon_en) begin
         if (sel_q && !sel_n) begin
            cyc = 0;
            n_sel++;
            chk_val(oclk, 1'h1);
         end
         if (stb_q && !(rd_n & wr_n)) begin
            lead_m = cyc;
            chk_val(oclk, edge_lvl());
         end
         if (!stb_q && (rd_n & wr_n)) begin
            act_m = cyc - lead_m;
            chk_val(oclk, edge_lvl());
         end
         if (!sel_q && sel_n) begin
            tot_m = cyc;
            chk_val(oclk, edge_lvl());
         end
         if (!sel_n) begin
            chk_val(rnw, !cur_wr);
            chk_val(cur_wr ? rd_n : wr_n, 1'h1);
            chk_val(xaddr, cur_addr);
         end
      end
      sel_q = sel_n;
      stb_q = rd_n & wr_n;
   end

   // Program a zone, run one access, poke a refused request, check lengths
   task automatic run_row(input ezs_row_t r, input logic [ezs_pkg::ADDR_W-1:0] a,
                          input int gap);
      int n;
      int s0;
      @(negedge mclk);
      cfg.rd = {r.ld, r.ac, r.tr};
      cfg.wr = {r.ld, r.ac, r.tr};
      cfg.period_doubler = r.dbl;
      cfg.ready_sampling_enable = r.use_rdy;
      cfg.ready_async_select = r.asy;
      cfg.output_clock_half = r.half;
      hold = r.hold;
      repeat (gap) @(negedge mclk);
      s0 = n_sel;
      cur_wr = r.wr;
      cur_addr = a;
      start = 1'h1;
      wr = r.wr;
      addr = a;
      @(negedge mclk);
      start = 1'h0;
      @(negedge mclk);
      chk_val(busy, 1'h1);
      start = 1'h1;
      addr = ~a;
      @(negedge mclk);
      start = 1'h0;
      addr = a;
      n = 0;
      while (done !== 1'h1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      chk_val(done, 1'h1);
      chk_val(busy, 1'h0);
      chk_num(n_sel - s0, 1);
      chk_num(lead_m, r.e_ld);
      if (r.use_rdy && r.hold != 0) begin
         chk_num(act_m > r.e_ac && act_m <= r.e_ac + r.hold + 4, 1);
      end else begin
         chk_num(act_m, r.e_ac);
      end
      chk_num(tot_m - lead_m - act_m, r.e_tr);
      chk_val(xaddr, a);
   endtask

   // Print counts and verdict, then stop
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      #200000;  // Several times the expected length of all tests
      err_total++;
      finish_test();
   end

   // Main sequence
   initial begin
      int n;
      nrst = 1'h0;
      start = 1'h0;
      wr = 1'h0;
      addr = '0;
      cfg = '0;
      hold = 4'h0;
      mon_en = 1'h0;
      rows[0] = '{0, 1, 1, 1, 0, 0, 0, 0, 0, 1, 2, 1};   // Read, full rate
      rows[1] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 1, 2, 1};   // Write, full rate
      rows[2] = '{0, 2, 3, 3, 1, 0, 0, 0, 0, 4, 7, 6};   // Doubled fields
      rows[3] = '{1, 1, 2, 0, 0, 1, 0, 0, 0, 1, 3, 0};   // Half rate, odd lead
      rows[4] = '{0, 2, 1, 1, 0, 1, 0, 0, 0, 2, 2, 1};   // Half rate, even lead
      rows[5] = '{1, 1, 1, 0, 1, 1, 1, 1, 0, 2, 3, 0};   // Async 1/1/0 doubled
      rows[6] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0};   // All-zero fields run as set
      rows[7] = '{0, 1, 1, 0, 0, 0, 1, 0, 0, 1, 2, 0};   // Sync ready, always ready
      rows[8] = '{0, 1, 2, 0, 0, 0, 0, 0, 6, 1, 3, 0};   // Ready low but ignored
      rows[9] = '{1, 1, 1, 0, 0, 1, 1, 0, 5, 1, 2, 0};   // Sync waits, half rate
      rows[10] = '{0, 1, 2, 0, 0, 1, 1, 1, 6, 1, 3, 0};  // Async waits
      rows[11] = '{0, 3, 1, 1, 0, 1, 0, 0, 0, 3, 2, 1};  // Odd lead, odd lead+active
      repeat (RST_START) @(negedge mclk);
      nrst = 1'h1;
      // Timing side leaves reset a few timing edges later; idle levels equal reset levels
      repeat (RST_CYC) @(negedge mclk);
      chk_val({sel_n, rd_n, wr_n, rnw, busy, done}, 6'h3C);
      mon_en = 1'h1;
      foreach (rows[i]) run_row(rows[i], 19'(32'h101 * (i + 1)), 40);
      run_row(rows[11], 19'h7FFFF, 0);  // Back to back
      // Reset in the middle of an access
      @(negedge mclk);
      cur_wr = 1'h0;
      cur_addr = 19'h2AAAA;
      addr = 19'h2AAAA;
      wr = 1'h0;
      start = 1'h1;
      @(negedge mclk);
      start = 1'h0;
      n = 0;
      while (sel_n !== 1'h0 && n < 500) begin
         @(negedge mclk);
         n++;
      end
      chk_val(sel_n, 1'h0);
      mon_en = 1'h0;
      nrst = 1'h0;
      repeat (RST_CYC) @(negedge mclk);
      chk_val({sel_n, rd_n, wr_n, rnw, busy, done}, 6'h3C);
      nrst = 1'h1;
      repeat (RST_CYC) @(negedge mclk);
      mon_en = 1'h1;
      run_row(rows[0], 19'h00055, 40);  // Recovery after reset
      finish_test();
   end
endmodule
